/* File: rtl/sdram_cmd_pkg.sv */
// Shared constants and types for the SDRAM command and bank-state logic
package sdram_cmd_pkg;
    localparam int CLK_MHZ               = 20;
    localparam int PRECHARGE_TIME_NS     = 18;
    localparam int ACTIVATE_TO_ACCESS_NS = 18;
    localparam int MODE_LOAD_WAIT_NS     = 12;
    localparam int SELF_REFRESH_EXIT_NS  = 120;

    // Least times round up, never below one cycle
    function automatic int cycles_up(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int PRECHARGE_CYC      = cycles_up(PRECHARGE_TIME_NS);
    localparam int ACTIVATE_CYC       = cycles_up(ACTIVATE_TO_ACCESS_NS);
    localparam int MODE_LOAD_CYC      = cycles_up(MODE_LOAD_WAIT_NS);
    localparam int SELF_REFRESH_X_CYC = cycles_up(SELF_REFRESH_EXIT_NS);

    localparam int BANKS       = 4;
    localparam int TIMER_W     = 8;
    localparam int OPCODE_W    = 12;
    localparam int AP_BIT      = 10;
    localparam int REFRESH_W   = 13;
    localparam int BURST_LEN_W = 4;

    typedef enum logic [3:0] {
        CMD_INHIBIT   = 4'h0,
        CMD_NOP       = 4'h1,
        CMD_ACTIVATE  = 4'h2,
        CMD_READ      = 4'h3,
        CMD_WRITE     = 4'h4,
        CMD_TERMINATE = 4'h5,
        CMD_PRECHARGE = 4'h6,
        CMD_REFRESH   = 4'h7,
        CMD_MODE_LOAD = 4'h8
    } cmd_t;

    typedef enum logic [7:0] {
        BANK_IDLE        = 8'h01,
        BANK_ACTIVATING  = 8'h02,
        BANK_ACTIVE      = 8'h04,
        BANK_READ        = 8'h08,
        BANK_WRITE       = 8'h10,
        BANK_READ_AP     = 8'h20,
        BANK_WRITE_AP    = 8'h40,
        BANK_PRECHARGING = 8'h80
    } bank_state_t;

    // Register byte offsets on the bus
    localparam logic [4:0] REG_STATUS    = 5'h00;
    localparam logic [4:0] REG_MODE      = 5'h04;
    localparam logic [4:0] REG_REFRESH   = 5'h08;
    localparam logic [4:0] REG_BURST_CFG = 5'h0C;
    localparam logic [4:0] REG_ROW_BASE  = 5'h10;

    localparam logic [BURST_LEN_W-1:0] BURST_CFG_RESET = 4'h8;

    // Status word field positions
    localparam int ST_IDLE_LSB = 0;
    localparam int ST_OPEN_LSB = 4;
    localparam int ST_SELF_REF = 8;
    localparam int ST_DEEP     = 9;
    localparam int ST_XSR      = 10;
    localparam int ST_BURST    = 11;
    localparam int ST_MODE_BSY = 12;
endpackage

/* File: rtl/sdram_bank_tracker.sv */
// Per-bank state machine: activate, access, auto precharge, precharge
module sdram_bank_tracker #(
    parameter int PRE_CYC = sdram_cmd_pkg::PRECHARGE_CYC,
    parameter int ACT_CYC = sdram_cmd_pkg::ACTIVATE_CYC
) (
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic                        do_act,
    input  wire logic                        do_rd,
    input  wire logic                        do_wr,
    input  wire logic                        do_pre,
    input  wire logic                        auto_pre,
    input  wire logic                        burst_end,
    output sdram_cmd_pkg::bank_state_t       state
);
    logic [sdram_cmd_pkg::TIMER_W-1:0] timer;
    logic                              timer_done;

    assign timer_done = (timer <= sdram_cmd_pkg::TIMER_W'(1));

    // Bank state transitions
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= sdram_cmd_pkg::BANK_IDLE;
        end else begin
            case (state)
                sdram_cmd_pkg::BANK_IDLE: begin
                    // Precharge to an idle bank leaves it idle
                    if (do_act)
                        state <= sdram_cmd_pkg::BANK_ACTIVATING; // [RULE4] [RULE20] [RULE26]
                end
                sdram_cmd_pkg::BANK_ACTIVATING: begin
                    if (timer_done)
                        state <= sdram_cmd_pkg::BANK_ACTIVE; // [RULE20]
                end
                sdram_cmd_pkg::BANK_ACTIVE, sdram_cmd_pkg::BANK_READ,
                sdram_cmd_pkg::BANK_WRITE: begin
                    if (do_pre)
                        state <= sdram_cmd_pkg::BANK_PRECHARGING; // [RULE17] [RULE18]
                    else if (do_rd)
                        state <= auto_pre ? sdram_cmd_pkg::BANK_READ_AP
                                          : sdram_cmd_pkg::BANK_READ; // [RULE6]
                    else if (do_wr)
                        state <= auto_pre ? sdram_cmd_pkg::BANK_WRITE_AP
                                          : sdram_cmd_pkg::BANK_WRITE; // [RULE8]
                    else if (burst_end && state != sdram_cmd_pkg::BANK_ACTIVE)
                        state <= sdram_cmd_pkg::BANK_ACTIVE; // [RULE12]
                end
                sdram_cmd_pkg::BANK_READ_AP, sdram_cmd_pkg::BANK_WRITE_AP: begin
                    if (burst_end || do_pre)
                        state <= sdram_cmd_pkg::BANK_PRECHARGING; // [RULE6] [RULE8]
                end
                sdram_cmd_pkg::BANK_PRECHARGING: begin
                    if (timer_done)
                        state <= sdram_cmd_pkg::BANK_IDLE; // [RULE11]
                end
                default: state <= sdram_cmd_pkg::BANK_IDLE;
            endcase
        end
    end

    // Timer loaded on entry to a timed state, counts down inside it
    always_ff @(posedge mclk) begin
        if (rst) begin
            timer <= '0;
        end else if (state == sdram_cmd_pkg::BANK_IDLE && do_act) begin
            timer <= sdram_cmd_pkg::TIMER_W'(ACT_CYC);
        end else if (state != sdram_cmd_pkg::BANK_PRECHARGING
                     && state != sdram_cmd_pkg::BANK_ACTIVATING
                     && state != sdram_cmd_pkg::BANK_IDLE
                     && (do_pre || ((state == sdram_cmd_pkg::BANK_READ_AP
                         || state == sdram_cmd_pkg::BANK_WRITE_AP) && burst_end))) begin
            timer <= sdram_cmd_pkg::TIMER_W'(PRE_CYC);
        end else if (timer != '0) begin
            timer <= timer - sdram_cmd_pkg::TIMER_W'(1);
        end
    end
endmodule

/* File: rtl/sdram_cmd_bank.sv */
// Command decode, bank tracking, burst engine and register slave of the SDRAM
// Notes on behaviour
// [RULE1] Selected no-operation registers nothing; running operations carry on.
// [RULE2] Mode load only with all banks idle; op-code on address and banks. Code loads only addr bits, bank pins unused.
// [RULE3] After mode load only inhibit or no-operation until its wait elapses.
// [RULE4] Activate opens the addressed row in the selected bank until precharged.
// [RULE5] Controller precharges a bank before opening another row there.
// [RULE6] Read picks bank and column; bit ten high precharges at burst end.
// [RULE7] Read byte mask high floats its lanes two clocks later, else drives.
// [RULE8] Write picks bank and column; bit ten high precharges after burst.
// [RULE9] Write byte mask high in the data cycle blocks that byte.
// [RULE10] Precharge with bit ten high closes all banks, else only selected.
// [RULE11] Precharged bank idles after precharge time; activate before access.
// [RULE12] Burst terminate cuts the most recent read or write burst.
// [RULE13] Auto refresh takes its row from the internal counter.
// [RULE14] Refresh with clock gate low enters self refresh; inputs ignored.
// [RULE15] Deep sleep entry needs all idle, gate low, terminate encoding.
// [RULE16] Deep sleep ends when clock gate goes high.
// [RULE17] Precharge in read state cuts the read; read, write, terminate accepted.
// [RULE18] Precharge in write state cuts the write; read, write, terminate accepted.
// [RULE19] Idle bank takes activate, precharge, refresh, mode load; last two all idle.
// [RULE20] Activate enters activating, active after activate-to-access time.
// [RULE21] No command to a bank while it precharges or activates.
// [RULE22] Command table only with gate high twice and self refresh exit done.
// [RULE23] Clock gate held high except for self refresh and deep sleep entry.
// [RULE24] Terminate encoding means deep sleep entry when the clock gate is low.
// [RULE25] Mode op-code is the twelve low address bits.
// [RULE26] Precharge to an idle bank changes nothing for it.
// [RULE27] Each of the four banks has its own state machine.
module sdram_cmd_bank #(
    parameter int ADDR_W   = 13,
    parameter int COL_W    = 4,
    parameter int DQ_W     = 16,
    parameter int PRE_CYC  = sdram_cmd_pkg::PRECHARGE_CYC,
    parameter int ACT_CYC  = sdram_cmd_pkg::ACTIVATE_CYC,
    parameter int MODE_CYC = sdram_cmd_pkg::MODE_LOAD_CYC,
    parameter int XSR_CYC  = sdram_cmd_pkg::SELF_REFRESH_X_CYC
) (
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic                clock_gate_in,
    input  wire logic                chip_select_n,
    input  wire logic                row_strobe_n,
    input  wire logic                col_strobe_n,
    input  wire logic                write_enable_n,
    input  wire logic                bank_select_low,
    input  wire logic                bank_select_high,
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic [DQ_W/8-1:0]   byte_mask,
    input  wire logic [DQ_W-1:0]     dq_in,
    output logic      [DQ_W-1:0]     dq_out,
    output logic      [DQ_W/8-1:0]   dq_oe,
    input  wire logic [4:0]          wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic                wb_we_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    output logic                     self_refresh_on,
    output logic                     deep_sleep_on
);
    localparam int LANES = DQ_W / 8;
    localparam int NB    = sdram_cmd_pkg::BANKS;
    localparam int IDX_W = 2 + COL_W;
    localparam int DEPTH = NB << COL_W;
    localparam int BLW   = sdram_cmd_pkg::BURST_LEN_W;
    localparam int TW    = sdram_cmd_pkg::TIMER_W;

    // Pin encoding to command; chip select high is an inhibit
    function automatic sdram_cmd_pkg::cmd_t decode_cmd(input logic [3:0] pins);
        casez (pins)
            4'b1???: decode_cmd = sdram_cmd_pkg::CMD_INHIBIT;
            4'b0111: decode_cmd = sdram_cmd_pkg::CMD_NOP;
            4'b0011: decode_cmd = sdram_cmd_pkg::CMD_ACTIVATE;
            4'b0101: decode_cmd = sdram_cmd_pkg::CMD_READ;
            4'b0100: decode_cmd = sdram_cmd_pkg::CMD_WRITE;
            4'b0110: decode_cmd = sdram_cmd_pkg::CMD_TERMINATE;
            4'b0010: decode_cmd = sdram_cmd_pkg::CMD_PRECHARGE;
            4'b0001: decode_cmd = sdram_cmd_pkg::CMD_REFRESH;
            default: decode_cmd = sdram_cmd_pkg::CMD_MODE_LOAD;
        endcase
    endfunction

    // A bank holding an open row can take a read or write
    function automatic logic row_open(input sdram_cmd_pkg::bank_state_t s);
        row_open = (s == sdram_cmd_pkg::BANK_ACTIVE) || (s == sdram_cmd_pkg::BANK_READ)
                || (s == sdram_cmd_pkg::BANK_WRITE) || (s == sdram_cmd_pkg::BANK_READ_AP)
                || (s == sdram_cmd_pkg::BANK_WRITE_AP);
    endfunction

    sdram_cmd_pkg::cmd_t         cmd;
    sdram_cmd_pkg::bank_state_t  bank_state [NB];
    logic [1:0]                  bank_sel;
    logic [NB-1:0]               tgt;
    logic [NB-1:0]               idle_vec;
    logic [NB-1:0]               open_vec;
    logic [NB-1:0]               act_v;
    logic [NB-1:0]               pre_v;
    logic [NB-1:0]               end_v;
    logic [ADDR_W-1:0]           open_row [NB];
    logic                        all_idle;
    logic                        cke_prev;
    logic                        table_ok;
    logic                        start_rd;
    logic                        start_wr;
    logic                        start;
    logic                        bst;
    logic                        cut;
    logic                        last_tick;
    logic                        beat;
    logic                        beat_wr;
    logic [IDX_W-1:0]            beat_idx;
    logic                        burst_on;
    logic                        burst_wr;
    logic                        burst_cont;
    logic [1:0]                  burst_bank;
    logic [COL_W-1:0]            burst_col;
    logic [BLW-1:0]              burst_left;
    logic [BLW-1:0]              burst_len;
    logic [DQ_W-1:0]             mem [DEPTH];
    logic                        rd_v1;
    logic [DQ_W-1:0]             rd_d1;
    logic [LANES-1:0]            mask_d1;
    logic [sdram_cmd_pkg::OPCODE_W-1:0]  mode_reg;
    logic [TW-1:0]               mode_cnt;
    logic [sdram_cmd_pkg::REFRESH_W-1:0] refresh_row;
    logic [TW-1:0]               xsr_cnt;
    logic [31:0]                 status_word;
    logic [31:0]                 next_rdata;
    logic                        wb_req;

    // Command decode and the conditions under which the table applies
    assign cmd      = decode_cmd({chip_select_n, row_strobe_n, col_strobe_n, write_enable_n});
    assign bank_sel = {bank_select_high, bank_select_low};
    assign all_idle = &idle_vec;
    assign table_ok = cke_prev && clock_gate_in && !self_refresh_on && !deep_sleep_on
                   && (xsr_cnt == '0); // [RULE22] [RULE14] [RULE1]
    assign start_rd = table_ok && cmd == sdram_cmd_pkg::CMD_READ
                   && open_vec[bank_sel]; // [RULE11]
    assign start_wr = table_ok && cmd == sdram_cmd_pkg::CMD_WRITE
                   && open_vec[bank_sel]; // [RULE11]
    assign start    = start_rd || start_wr;
    assign bst      = table_ok && cmd == sdram_cmd_pkg::CMD_TERMINATE; // [RULE24]

    // Per-bank command steering
    for (genvar g = 0; g < NB; g++) begin : g_bank
        assign tgt[g]      = (bank_sel == 2'(g));
        assign idle_vec[g] = (bank_state[g] == sdram_cmd_pkg::BANK_IDLE);
        assign open_vec[g] = row_open(bank_state[g]);
        assign act_v[g]    = table_ok && cmd == sdram_cmd_pkg::CMD_ACTIVATE && tgt[g];
        assign pre_v[g]    = table_ok && cmd == sdram_cmd_pkg::CMD_PRECHARGE
                          && (addr[sdram_cmd_pkg::AP_BIT] || tgt[g]); // [RULE10]
        // Burst end: natural end, terminate, or another bank taking the bus
        assign end_v[g]    = burst_on && burst_bank == 2'(g)
                          && (last_tick || bst || (start && bank_sel != 2'(g))); // [RULE12]

        sdram_bank_tracker #(
            .PRE_CYC (PRE_CYC),
            .ACT_CYC (ACT_CYC)
        ) u_bank (
            .mclk      (mclk),
            .rst       (rst),
            .do_act    (act_v[g]),
            .do_rd     (start_rd && tgt[g]),
            .do_wr     (start_wr && tgt[g]),
            .do_pre    (pre_v[g]),
            .auto_pre  (addr[sdram_cmd_pkg::AP_BIT]),
            .burst_end (end_v[g]),
            .state     (bank_state[g])
        ); // [RULE27]

        // Row held open until the bank is precharged
        always_ff @(posedge mclk) begin
            if (rst)
                open_row[g] <= '0;
            else if (act_v[g] && idle_vec[g])
                open_row[g] <= addr; // [RULE4]
        end
    end

    // Burst beat selection; the command cycle carries the first beat
    assign last_tick = burst_on && !burst_cont && burst_left == '0;
    assign cut       = bst || (burst_on && pre_v[burst_bank]); // [RULE17] [RULE18]
    assign beat      = start || (burst_on && !last_tick && !cut);
    assign beat_wr   = start ? start_wr : burst_wr;
    assign beat_idx  = start ? {bank_sel, addr[COL_W-1:0]} : {burst_bank, burst_col};

    // Burst engine tracks only the most recent burst
    always_ff @(posedge mclk) begin
        if (rst) begin
            burst_on   <= 1'b0;
            burst_wr   <= 1'b0;
            burst_cont <= 1'b0;
            burst_bank <= '0;
            burst_col  <= '0;
            burst_left <= '0;
        end else if (start) begin
            burst_on   <= 1'b1; // [RULE6] [RULE8]
            burst_wr   <= start_wr;
            burst_cont <= (burst_len == '0);
            burst_bank <= bank_sel;
            burst_col  <= addr[COL_W-1:0] + COL_W'(1);
            burst_left <= burst_len - BLW'(1);
        end else if (last_tick || cut) begin
            burst_on   <= 1'b0; // [RULE12]
        end else if (beat) begin
            burst_col  <= burst_col + COL_W'(1);
            if (!burst_cont)
                burst_left <= burst_left - BLW'(1);
        end
    end

    // Array write; a masked lane keeps its old byte
    always_ff @(posedge mclk) begin
        if (beat && beat_wr) begin
            for (int l = 0; l < LANES; l++) begin
                if (!byte_mask[l])
                    mem[beat_idx][l*8 +: 8] <= dq_in[l*8 +: 8]; // [RULE9]
            end
        end
    end

    // Read pipe: data and mask both take two clocks to reach the pins
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_v1   <= 1'b0;
            rd_d1   <= '0;
            mask_d1 <= '0;
            dq_out  <= '0;
            dq_oe   <= '0;
        end else begin
            rd_v1   <= beat && !beat_wr;
            rd_d1   <= mem[beat_idx];
            mask_d1 <= byte_mask;
            dq_out  <= rd_d1;
            for (int l = 0; l < LANES; l++)
                dq_oe[l] <= rd_v1 && !mask_d1[l]; // [RULE7]
        end
    end

    // Mode register load; the wait is only reported, the controller keeps it
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_reg <= '0;
            mode_cnt <= '0;
        end else if (table_ok && cmd == sdram_cmd_pkg::CMD_MODE_LOAD && all_idle) begin
            mode_reg <= addr[sdram_cmd_pkg::OPCODE_W-1:0]; // [RULE25] [RULE19] [RULE2]
            mode_cnt <= TW'(MODE_CYC); // [RULE3]
        end else if (mode_cnt != '0) begin
            mode_cnt <= mode_cnt - TW'(1);
        end
    end

    // Auto refresh steps the internal row counter, address pins unused
    always_ff @(posedge mclk) begin
        if (rst)
            refresh_row <= '0;
        else if (table_ok && cmd == sdram_cmd_pkg::CMD_REFRESH && all_idle)
            refresh_row <= refresh_row + sdram_cmd_pkg::REFRESH_W'(1); // [RULE13] [RULE19]
    end

    // Clock gate history for entry detection
    always_ff @(posedge mclk) begin
        if (rst)
            cke_prev <= 1'b0;
        else
            cke_prev <= clock_gate_in;
    end

    // Self refresh; the exit wait blocks the command table afterwards
    always_ff @(posedge mclk) begin
        if (rst) begin
            self_refresh_on <= 1'b0;
            xsr_cnt         <= '0;
        end else if (self_refresh_on) begin
            if (clock_gate_in) begin
                self_refresh_on <= 1'b0;
                xsr_cnt         <= TW'(XSR_CYC); // [RULE22]
            end
        end else if (cke_prev && !clock_gate_in && !deep_sleep_on && xsr_cnt == '0
                     && cmd == sdram_cmd_pkg::CMD_REFRESH && all_idle) begin
            self_refresh_on <= 1'b1; // [RULE14]
        end else if (xsr_cnt != '0) begin
            xsr_cnt <= xsr_cnt - TW'(1);
        end
    end

    // Deep sleep shares the terminate encoding with the gate low
    always_ff @(posedge mclk) begin
        if (rst)
            deep_sleep_on <= 1'b0;
        else if (deep_sleep_on && clock_gate_in)
            deep_sleep_on <= 1'b0; // [RULE16]
        else if (cke_prev && !clock_gate_in && !self_refresh_on && xsr_cnt == '0
                 && cmd == sdram_cmd_pkg::CMD_TERMINATE && all_idle)
            deep_sleep_on <= 1'b1; // [RULE24] [RULE15]
    end

    // Status word seen by software
    always_comb begin
        status_word = '0;
        status_word[sdram_cmd_pkg::ST_IDLE_LSB +: NB] = idle_vec;
        status_word[sdram_cmd_pkg::ST_OPEN_LSB +: NB] = open_vec;
        status_word[sdram_cmd_pkg::ST_SELF_REF]       = self_refresh_on;
        status_word[sdram_cmd_pkg::ST_DEEP]           = deep_sleep_on;
        status_word[sdram_cmd_pkg::ST_XSR]            = (xsr_cnt != '0);
        status_word[sdram_cmd_pkg::ST_BURST]          = burst_on;
        status_word[sdram_cmd_pkg::ST_MODE_BSY]       = (mode_cnt != '0);
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        next_rdata = '0;
        case (wb_adr_i)
            sdram_cmd_pkg::REG_STATUS:    next_rdata = status_word;
            sdram_cmd_pkg::REG_MODE:      next_rdata = 32'(mode_reg);
            sdram_cmd_pkg::REG_REFRESH:   next_rdata = 32'(refresh_row);
            sdram_cmd_pkg::REG_BURST_CFG: next_rdata = 32'(burst_len);
            default: begin
                for (int b = 0; b < NB; b++) begin
                    if (wb_adr_i == sdram_cmd_pkg::REG_ROW_BASE + 5'(4 * b))
                        next_rdata = 32'(open_row[b]);
                end
            end
        endcase
    end

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Bus slave: answer one cycle after the request, drop ack after one cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= (wb_req && !wb_we_i) ? next_rdata : 32'h0000_0000;
        end
    end

    // Burst length control; zero selects continuous page
    always_ff @(posedge mclk) begin
        if (rst)
            burst_len <= sdram_cmd_pkg::BURST_CFG_RESET;
        else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == sdram_cmd_pkg::REG_BURST_CFG)
            burst_len <= wb_dat_i[BLW-1:0];
    end
endmodule

/* File: bench/sdram_cmd_bank_assertions.sv */
// Port-level checker for the SDRAM command and bank-state block
module sdram_cmd_bank_checker (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        clock_gate_in,
    input wire logic        chip_select_n,
    input wire logic        row_strobe_n,
    input wire logic        col_strobe_n,
    input wire logic        write_enable_n,
    input wire logic [1:0]  byte_mask,
    input wire logic [1:0]  dq_oe,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        self_refresh_on,
    input wire logic        deep_sleep_on
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Entry lands one or two edges after its command
    wire logic [3:0] pins = {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n};
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
    property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("bus request not answered");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_mask_float; (dq_oe & $past(byte_mask, 2)) == 2'h0; endproperty
    a_mask_float: assert property (p_mask_float) else $error("masked lane driven");
    property p_sr_cause;
        $rose(self_refresh_on) |-> $past(pins == 4'h1 && !clock_gate_in)
            || $past(pins == 4'h1 && !clock_gate_in, 2);
    endproperty
    a_sr_cause: assert property (p_sr_cause) else $error("self refresh without cmd");
    property p_sr_hold; self_refresh_on && !clock_gate_in |=> self_refresh_on; endproperty
    a_sr_hold: assert property (p_sr_hold) else $error("self refresh left early");
    property p_dp_cause;
        $rose(deep_sleep_on) |-> $past(pins == 4'h6 && !clock_gate_in)
            || $past(pins == 4'h6 && !clock_gate_in, 2);
    endproperty
    a_dp_cause: assert property (p_dp_cause) else $error("deep sleep without cmd");
    property p_dp_exit; deep_sleep_on && clock_gate_in |-> ##[1:2] !deep_sleep_on; endproperty
    a_dp_exit: assert property (p_dp_exit) else $error("deep sleep not left");
    c_masked_read: cover property (dq_oe == 2'h2);
    c_self_ref: cover property ($rose(self_refresh_on));
    c_deep: cover property ($rose(deep_sleep_on));
endmodule
bind sdram_cmd_bank sdram_cmd_bank_checker u_chk (.*);

/* File: bench/sdram_ctrl_model.sv */
// Controller-side model: command code to the four command pins
module sdram_ctrl_model (
    input  sdram_cmd_pkg::cmd_t cmd,
    output logic [3:0]          pins
);
    // Pin patterns {cs,ras,cas,we} indexed by cmd_t; mode load drives all four pins low
    localparam logic [3:0] ENC [9] = '{4'hF, 4'h7, 4'h3, 4'h5, 4'h4, 4'h6, 4'h2, 4'h1, 4'h0};
    assign pins = ENC[cmd];
endmodule

/* File: bench/sdram_cmd_bank_bench.sv */
// Self-checking bench: command pins and Wishbone register access
module sdram_cmd_bank_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0, rst = 1'b1, clock_gate_in = 1'b1;
    logic        bank_select_low = 1'b0, bank_select_high = 1'b0;
    logic [12:0] addr = 13'h0000;
    logic [1:0]  byte_mask = 2'h0, dq_oe;
    logic [15:0] dq_in = 16'h0000, dq_out;
    logic [4:0]  wb_adr_i = 5'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [3:0]  wb_sel_i = 4'hF;
    logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
    logic        self_refresh_on, deep_sleep_on;
    wire logic   chip_select_n, row_strobe_n, col_strobe_n, write_enable_n;
    sdram_cmd_pkg::cmd_t cmd = sdram_cmd_pkg::CMD_NOP;
    int          error_cnt = 0, n_tests = 0, ticks = 0;
    sdram_ctrl_model ctrl (.cmd(cmd), .pins({chip_select_n, row_strobe_n, col_strobe_n,
        write_enable_n}));
    sdram_cmd_bank DUT (.*);
    initial forever #25 mclk = ~mclk;
    task automatic print_verdict();
        if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Codes follow cmd_t; ba is {bank, address}
    task automatic issue(input logic [3:0] c, input logic [14:0] ba, input logic [1:0] m,
                         input logic [15:0] d, input logic g);
        @(posedge mclk);
        cmd <= sdram_cmd_pkg::cmd_t'(c);
        {bank_select_high, bank_select_low, addr} <= ba;
        byte_mask <= m;
        dq_in <= d;
        clock_gate_in <= g;
    endtask
    // Classic cycle: hold until ack, then release
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do @(posedge mclk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    // A hang counts as a mismatch
    always @(posedge mclk) begin
        ticks++;
        if (ticks == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        issue(4'h8, 15'h0123, 2'h0, 16'h0, 1'b1);
        wb(1'b0, 5'h0C, 32'h0);
        chk(rd, 32'h8);
        wb(1'b0, 5'h04, 32'h0);
        chk(rd, 32'h123);
        wb(1'b1, 5'h0C, 32'h2);
        issue(4'h2, 15'h0005, 2'h0, 16'h0, 1'b1);
        issue(4'h1, 15'h0, 2'h0, 16'h0, 1'b1);
        wb(1'b0, 5'h10, 32'h0);
        chk(rd, 32'h5);
        issue(4'h4, 15'h0003, 2'h0, 16'h1111, 1'b1);
        issue(4'h1, 15'h0, 2'h0, 16'h2222, 1'b1);
        issue(4'h4, 15'h0003, 2'h0, 16'h3333, 1'b1);
        issue(4'h1, 15'h0, 2'h2, 16'h4444, 1'b1);
        issue(4'h3, 15'h0003, 2'h0, 16'h0, 1'b1);
        issue(4'h1, 15'h0, 2'h1, 16'h0, 1'b1);
        issue(4'h1, 15'h0, 2'h0, 16'h0, 1'b1);
        #1 chk({dq_oe, dq_out}, {2'h3, 16'h3333});
        issue(4'h1, 15'h0, 2'h0, 16'h0, 1'b1);
        #1 chk({dq_oe, dq_out[15:8]}, {2'h2, 8'h22});
        issue(4'h6, 15'h0400, 2'h0, 16'h0, 1'b1);
        repeat (2) issue(4'h1, 15'h0, 2'h0, 16'h0, 1'b1);
        wb(1'b0, 5'h00, 32'h0);
        chk(rd[7:0], 8'h0F);
        issue(4'h7, 15'h0, 2'h0, 16'h0, 1'b0);
        repeat (2) issue(4'h1, 15'h0, 2'h0, 16'h0, 1'b0);
        #1 chk(self_refresh_on, 1'b1);
        repeat (7) issue(4'h1, 15'h0, 2'h0, 16'h0, 1'b1);
        chk(self_refresh_on, 1'b0);
        issue(4'h5, 15'h0, 2'h0, 16'h0, 1'b0);
        repeat (2) issue(4'h1, 15'h0, 2'h0, 16'h0, 1'b0);
        #1 chk(deep_sleep_on, 1'b1);
        repeat (3) issue(4'h1, 15'h0, 2'h0, 16'h0, 1'b1);
        #1 chk(deep_sleep_on, 1'b0);
        print_verdict();
    end
endmodule
